// ===== hw/can_mode_control.sv
// The implementer's own choices: the AXI4-Lite register port and the placing of the registers.
`timescale 1ns/1ps
module can_mode_control (
   input wire logic clk_i,
   input wire logic rst_n_i,
   // axi4-lite slave
   input wire logic [11:0] s_axi_awaddr_i,
   input wire logic s_axi_awvalid_i,
   output logic s_axi_awready_o,
   input wire logic [31:0] s_axi_wdata_i,
   input wire logic [3:0] s_axi_wstrb_i,
   input wire logic s_axi_wvalid_i,
   output logic s_axi_wready_o,
   output logic [1:0] s_axi_bresp_o,
   output logic s_axi_bvalid_o,
   input wire logic s_axi_bready_i,
   input wire logic [11:0] s_axi_araddr_i,
   input wire logic s_axi_arvalid_i,
   output logic s_axi_arready_o,
   output logic [31:0] s_axi_rdata_o,
   output logic [1:0] s_axi_rresp_o,
   output logic s_axi_rvalid_o,
   input wire logic s_axi_rready_i,
   // core side
   input wire logic tx_pending_i,
   input wire logic xfer_active_i,
   input wire logic rx_valid_i,
   output logic abort_all_tx_o,
   output logic module_on_o,
   output logic [2:0] current_mode_o,
   output logic rx_stamp_valid_o,
   output logic [15:0] rx_stamp_o
);
   import can_mode_pkg::*;

   // ************************************************************
   // state
   // ************************************************************
   typedef enum {ST_OFF, ST_ON, ST_DRAIN} power_e;
   power_e power;
   logic module_enable;
   logic abort_all_tx;
   logic [2:0] requested_mode;
   logic [2:0] current_mode;
   logic rx_timestamp_capture_en;
   logic module_active_flag;
   logic [3:0] settle;
   logic [15:0] rx_timestamp_timer;
   logic have_aw, have_w;
   logic [11:0] aw_addr;
   logic [31:0] w_data;
   logic [3:0] w_strb;
   logic do_write;
   logic ctl_write;

   // ************************************************************
   // axi4-lite write path
   // ************************************************************
   assign s_axi_awready_o = !have_aw && !s_axi_bvalid_o;
   assign s_axi_wready_o = !have_w && !s_axi_bvalid_o;
   assign do_write = have_aw && have_w && !s_axi_bvalid_o;
   assign ctl_write = do_write && (aw_addr[11:2] == ADDR_CONTROL[11:2]);

   // capture address and data in either order
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         have_aw <= 1'b0;
         have_w <= 1'b0;
         aw_addr <= 12'h000;
         w_data <= 32'h00000000;
         w_strb <= 4'h0;
      end else begin
         if (s_axi_awvalid_i && s_axi_awready_o) begin
            have_aw <= 1'b1;
            aw_addr <= s_axi_awaddr_i;
         end else if (do_write) begin
            have_aw <= 1'b0;
         end
         if (s_axi_wvalid_i && s_axi_wready_o) begin
            have_w <= 1'b1;
            w_data <= s_axi_wdata_i;
            w_strb <= s_axi_wstrb_i;
         end else if (do_write) begin
            have_w <= 1'b0;
         end
      end
   end

   // write response, error on unmapped or read-only address
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         s_axi_bvalid_o <= 1'b0;
         s_axi_bresp_o <= RESP_OKAY;
      end else if (do_write) begin
         s_axi_bvalid_o <= 1'b1;
         s_axi_bresp_o <= (aw_addr[11:2] == ADDR_CONTROL[11:2]) ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready_i) begin
         s_axi_bvalid_o <= 1'b0;
      end
   end

   // ************************************************************
   // control register
   // ************************************************************
   // writable fields, byte lanes honoured
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         module_enable <= 1'b0;
         requested_mode <= MODE_RESET;
         rx_timestamp_capture_en <= 1'b0;
      end else if (ctl_write) begin
         if (w_strb[1]) begin
            module_enable <= w_data[EN_BIT];
         end
         if (w_strb[2]) begin
            rx_timestamp_capture_en <= w_data[CAP_BIT];
         end
         if (w_strb[3]) begin
            requested_mode <= w_data[REQ_LSB +: 3];
         end
      end
   end

   // abort: software sets, hardware clears when nothing pending
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         abort_all_tx <= 1'b0;
      end else if (ctl_write && w_strb[3] && w_data[ABORT_BIT]) begin
         abort_all_tx <= 1'b1;
      end else if (abort_all_tx && !tx_pending_i) begin
         abort_all_tx <= 1'b0;
      end
   end
   assign abort_all_tx_o = abort_all_tx;

   // ************************************************************
   // power sequencing
   // ************************************************************
   // on disable, wait for transaction end before shutting down
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         power <= ST_OFF;
      end else begin
         case (power)
            ST_OFF: if (module_enable) power <= ST_ON;
            ST_ON: if (!module_enable) power <= ST_DRAIN;
            ST_DRAIN: begin
               if (module_enable) begin
                  power <= ST_ON;
               end else if (!xfer_active_i) begin
                  power <= ST_OFF;
               end
            end
            default: power <= ST_OFF;
         endcase
      end
   end
   assign module_active_flag = (power != ST_OFF);
   assign module_on_o = (power != ST_OFF);

   // ************************************************************
   // mode transition
   // ************************************************************
   // current mode follows request after settling and no transfer
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         current_mode <= MODE_RESET;
         settle <= 4'h0;
      end else if (requested_mode == current_mode) begin
         settle <= 4'h0;
      end else if (settle != SWITCH_CYCLES) begin
         settle <= settle + 4'h1;
      end else if (!xfer_active_i) begin
         current_mode <= requested_mode;
         settle <= 4'h0;
      end
   end
   assign current_mode_o = current_mode;

   // ************************************************************
   // receive time stamp
   // ************************************************************
   ts_timer u_timer (
      .clk_i(clk_i),
      .rst_n_i(rst_n_i),
      .run_i(rx_timestamp_capture_en && module_on_o),
      .count_o(rx_timestamp_timer)
   );

   // stamp valid received message
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rx_stamp_valid_o <= 1'b0;
         rx_stamp_o <= 16'h0000;
      end else begin
         rx_stamp_valid_o <= rx_valid_i && rx_timestamp_capture_en;
         if (rx_valid_i && rx_timestamp_capture_en) begin
            rx_stamp_o <= rx_timestamp_timer;
         end
      end
   end

   // ************************************************************
   // axi4-lite read path
   // ************************************************************
   assign s_axi_arready_o = !s_axi_rvalid_o;

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         s_axi_rvalid_o <= 1'b0;
         s_axi_rdata_o <= 32'h00000000;
         s_axi_rresp_o <= RESP_OKAY;
      end else if (s_axi_arvalid_i && s_axi_arready_o) begin
         s_axi_rvalid_o <= 1'b1;
         s_axi_rresp_o <= RESP_OKAY;
         s_axi_rdata_o <= 32'h00000000;
         case (s_axi_araddr_i[11:2])
            ADDR_CONTROL[11:2]: begin
               s_axi_rdata_o[ABORT_BIT] <= abort_all_tx;
               s_axi_rdata_o[REQ_LSB +: 3] <= requested_mode;
               s_axi_rdata_o[CUR_LSB +: 3] <= current_mode;
               s_axi_rdata_o[CAP_BIT] <= rx_timestamp_capture_en;
               s_axi_rdata_o[EN_BIT] <= module_enable;
               s_axi_rdata_o[BUSY_BIT] <= module_active_flag;
            end
            ADDR_TIMER[11:2]: s_axi_rdata_o[15:0] <= rx_timestamp_timer;
            default: s_axi_rresp_o <= RESP_SLVERR;
         endcase
      end else if (s_axi_rready_i) begin
         s_axi_rvalid_o <= 1'b0;
      end
   end

   // ************************************************************
   // checks
   // ************************************************************
   property p_abort_clear;
      @(posedge clk_i) disable iff (!rst_n_i)
      abort_all_tx && !tx_pending_i && !ctl_write |=> !abort_all_tx;
   endproperty
   a_abort_clear: assert property (p_abort_clear) else $error("abort not cleared");

   property p_abort_set;
      @(posedge clk_i) disable iff (!rst_n_i)
      ctl_write && w_strb[3] && w_data[ABORT_BIT] |=> abort_all_tx_o;
   endproperty
   a_abort_set: assert property (p_abort_set) else $error("abort not set");

   property p_mode_hold;
      @(posedge clk_i) disable iff (!rst_n_i)
      xfer_active_i |=> $stable(current_mode);
   endproperty
   a_mode_hold: assert property (p_mode_hold) else $error("mode changed mid transfer");

   property p_busy_drain;
      @(posedge clk_i) disable iff (!rst_n_i)
      power == ST_DRAIN && xfer_active_i && !module_enable |=> module_active_flag;
   endproperty
   a_busy_drain: assert property (p_busy_drain) else $error("busy dropped early");

   property p_stamp;
      @(posedge clk_i) disable iff (!rst_n_i)
      rx_valid_i && rx_timestamp_capture_en |=> rx_stamp_o == $past(rx_timestamp_timer);
   endproperty
   a_stamp: assert property (p_stamp) else $error("stamp wrong");

   property p_timer_halt;
      @(posedge clk_i) disable iff (!rst_n_i)
      !rx_timestamp_capture_en |=> $stable(rx_timestamp_timer) && !rx_stamp_valid_o;
   endproperty
   a_timer_halt: assert property (p_timer_halt) else $error("timer ran");

   property p_mode_settle;
      @(posedge clk_i) disable iff (!rst_n_i)
      $changed(current_mode) |-> $past(settle) == SWITCH_CYCLES;
   endproperty
   a_mode_settle: assert property (p_mode_settle) else $error("mode switched early");

   property p_on_off;
      @(posedge clk_i) disable iff (!rst_n_i)
      power != ST_ON && !module_enable && !xfer_active_i |=> !module_on_o;
   endproperty
   a_on_off: assert property (p_on_off) else $error("module still on");

   property p_abort_hold;
      @(posedge clk_i) disable iff (!rst_n_i)
      abort_all_tx && tx_pending_i |=> abort_all_tx;
   endproperty
   a_abort_hold: assert property (p_abort_hold) else $error("abort dropped while pending");

   property p_mode_source;
      @(posedge clk_i) disable iff (!rst_n_i)
      $changed(current_mode) |-> current_mode == $past(requested_mode);
   endproperty
   a_mode_source: assert property (p_mode_source) else $error("mode not from request");

   property p_drain_end;
      @(posedge clk_i) disable iff (!rst_n_i)
      power == ST_DRAIN && !module_enable && !xfer_active_i |=> !module_active_flag;
   endproperty
   a_drain_end: assert property (p_drain_end) else $error("busy stuck after drain");

   property p_stamp_pulse;
      @(posedge clk_i) disable iff (!rst_n_i)
      rx_valid_i && rx_timestamp_capture_en |=> rx_stamp_valid_o;
   endproperty
   a_stamp_pulse: assert property (p_stamp_pulse) else $error("stamp pulse missing");
endmodule // can_mode_control

// ===== hw/can_mode_pkg.sv
package can_mode_pkg;
   // register map, byte addresses
   localparam logic [11:0] ADDR_CONTROL = 12'h000;
   localparam logic [11:0] ADDR_STATUS = 12'h004;
   localparam logic [11:0] ADDR_TIMER = 12'h008;
   // control register field positions
   localparam int ABORT_BIT = 27;
   localparam int REQ_LSB = 24;
   localparam int CUR_LSB = 21;
   localparam int CAP_BIT = 20;
   localparam int EN_BIT = 15;
   localparam int BUSY_BIT = 11;
   // mode encodings
   localparam logic [2:0] MODE_NORMAL = 3'h0;
   localparam logic [2:0] MODE_DISABLE = 3'h1;
   localparam logic [2:0] MODE_LOOPBACK = 3'h2;
   localparam logic [2:0] MODE_LISTEN = 3'h3;
   localparam logic [2:0] MODE_CONFIG = 3'h4;
   localparam logic [2:0] MODE_LISTEN_ALL = 3'h7;
   // reset values
   localparam logic [2:0] MODE_RESET = MODE_CONFIG;
   // settling time for a mode change, in cycles
   localparam logic [3:0] SWITCH_CYCLES = 4'h8;
   // axi answer codes
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// ===== hw/ts_timer.sv
`timescale 1ns/1ps
module ts_timer (
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic run_i,
   output logic [15:0] count_o
);
   // free counter, held while not running
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         count_o <= 16'h0000;
      end else if (run_i) begin
         count_o <= count_o + 16'h0001;
      end
   end
endmodule // ts_timer

// ===== verif/core_model.sv
`timescale 1ns/1ps
// ****
// far-side core model
// ****
module core_model (
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic abort_i,
   input wire logic load_i,
   input wire logic go_i,
   input wire logic rx_i,
   output logic pend_o,
   output logic act_o,
   output logic rxv_o
);
   logic [4:0] acnt;
   logic [4:0] xcnt;
   // pending buffers, dropped 24 cycles into an abort
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         pend_o <= 1'b0;
         acnt <= 5'h0;
      end else if (load_i) begin
         pend_o <= 1'b1;
         acnt <= 5'h0;
      end else if (abort_i && pend_o) begin
         acnt <= acnt + 5'h1;
         if (acnt == 5'h17) begin
            pend_o <= 1'b0;
         end
      end
   end
   // bus transaction of 30 cycles
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         xcnt <= 5'h0;
      end else if (go_i) begin
         xcnt <= 5'h1e;
      end else if (xcnt != 5'h0) begin
         xcnt <= xcnt - 5'h1;
      end
   end
   assign act_o = (xcnt != 5'h0);
   // one-cycle message pulse
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rxv_o <= 1'b0;
      end else begin
         rxv_o <= rx_i;
      end
   end
endmodule // core_model

// ===== verif/tb.sv
`timescale 1ns/1ps
// ****
// bench
// ****
module tb;
   import can_mode_pkg::*;
   logic clk_i = 1'b0;
   logic rst_n_i = 1'b0;
   logic [11:0] awa = 12'h0;
   logic [11:0] ara = 12'h0;
   logic [31:0] wd = 32'h0;
   logic awv = 1'b0;
   logic wv = 1'b0;
   logic arv = 1'b0;
   logic ld = 1'b0;
   logic go = 1'b0;
   logic rxg = 1'b0;
   logic awr, wrdy, bv, arr, rv, pend, act, rxv, abt, on, sv;
   logic [1:0] br, rr;
   logic [31:0] rdat;
   logic [2:0] cm;
   logic [15:0] st;
   int cyc = 0;
   int err_total = 0;
   int checked = 0;
   always #2 clk_i = ~clk_i;
   can_mode_control u_dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .s_axi_awaddr_i(awa),
      .s_axi_awvalid_i(awv), .s_axi_awready_o(awr), .s_axi_wdata_i(wd), .s_axi_wstrb_i(4'hf),
      .s_axi_wvalid_i(wv), .s_axi_wready_o(wrdy), .s_axi_bresp_o(br), .s_axi_bvalid_o(bv),
      .s_axi_bready_i(1'b1), .s_axi_araddr_i(ara), .s_axi_arvalid_i(arv),
      .s_axi_arready_o(arr), .s_axi_rdata_o(rdat), .s_axi_rresp_o(rr), .s_axi_rvalid_o(rv),
      .s_axi_rready_i(1'b1), .tx_pending_i(pend), .xfer_active_i(act), .rx_valid_i(rxv),
      .abort_all_tx_o(abt), .module_on_o(on), .current_mode_o(cm),
      .rx_stamp_valid_o(sv), .rx_stamp_o(st));
   core_model u_core (.clk_i(clk_i), .rst_n_i(rst_n_i), .abort_i(abt), .load_i(ld),
      .go_i(go), .rx_i(rxg), .pend_o(pend), .act_o(act), .rxv_o(rxv));
   // ****
   // helpers
   // ****
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      checked++;
      if (g !== e) begin
         $display("BAD %s exp %h got %h", n, e, g);
         err_total++;
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge clk_i);
   endtask
   function automatic logic [31:0] ctl(logic ab, logic [2:0] q, logic cp, logic en);
      ctl = 32'h0;
      ctl[ABORT_BIT] = ab;
      ctl[REQ_LSB+:3] = q;
      ctl[CAP_BIT] = cp;
      ctl[EN_BIT] = en;
   endfunction
   // axi write, entered just after a rising edge
   task automatic axw(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
      logic ha, hw, hb;
      hb = 1'b0;
      awa <= a;
      awv <= 1'b1;
      wd <= d;
      wv <= 1'b1;
      while (!hb) begin
         @(negedge clk_i);
         ha = awv & awr;
         hw = wv & wrdy;
         hb = bv;
         r = br;
         @(posedge clk_i);
         if (ha) awv <= 1'b0;
         if (hw) wv <= 1'b0;
      end
   endtask
   task automatic axr(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
      logic h, hd;
      hd = 1'b0;
      ara <= a;
      arv <= 1'b1;
      while (!hd) begin
         @(negedge clk_i);
         h = arv & arr;
         hd = rv;
         d = rdat;
         r = rr;
         @(posedge clk_i);
         if (h) arv <= 1'b0;
      end
   endtask
   task automatic rx_pulse(output logic s);
      s = 1'b0;
      rxg <= 1'b1;
      tick(1);
      rxg <= 1'b0;
      repeat (4) begin
         @(negedge clk_i);
         if (sv === 1'b1) s = 1'b1;
         @(posedge clk_i);
      end
   endtask
   // ****
   // scenarios
   // ****
   task automatic t_reset;
      logic [31:0] d;
      logic [1:0] r;
      axr(ADDR_CONTROL, d, r);
      chk("ctl", ctl(0, MODE_RESET, 0, 0) | (32'(MODE_RESET) << CUR_LSB), d);
      chk("mode", MODE_RESET, cm);
      chk("on", 0, on);
      $display("t_reset done");
   endtask
   task automatic t_modes;
      // reserved codes never written
      logic [2:0] m [6] = '{MODE_NORMAL, MODE_DISABLE, MODE_LOOPBACK, MODE_LISTEN,
         MODE_LISTEN_ALL, MODE_CONFIG};
      logic [31:0] d;
      logic [1:0] r;
      int n;
      foreach (m[i]) begin
         axw(ADDR_CONTROL, ctl(0, m[i], 0, 1), r);
         chk("hold", m[(i + 5) % 6], cm);
         n = 0;
         while (cm !== m[i] && n < 40) begin
            @(negedge clk_i);
            n++;
         end
         chk("settle", 32'(SWITCH_CYCLES) + 32'h1, n);
         @(posedge clk_i);
         axr(ADDR_CONTROL, d, r);
         chk("cur", m[i], d[CUR_LSB+:3]);
      end
      $display("t_modes done");
   endtask
   task automatic t_abort;
      logic [31:0] d;
      logic [1:0] r;
      int n;
      ld <= 1'b1;
      tick(1);
      ld <= 1'b0;
      axw(ADDR_CONTROL, ctl(1, MODE_CONFIG, 0, 1), r);
      chk("abort_o", 1, abt);
      axw(ADDR_CONTROL, ctl(0, MODE_CONFIG, 0, 1), r);
      axr(ADDR_CONTROL, d, r);
      chk("abort_kept", 1, d[ABORT_BIT]);
      n = 0;
      while (abt !== 1'b0 && n < 40) begin
         @(negedge clk_i);
         n++;
      end
      chk("abort_clr", 1, n < 40 && pend === 1'b0);
      @(posedge clk_i);
      axr(ADDR_CONTROL, d, r);
      chk("abort_bit", 0, d[ABORT_BIT]);
      $display("t_abort done");
   endtask
   task automatic t_power;
      logic [31:0] d;
      logic [1:0] r;
      int n;
      go <= 1'b1;
      tick(1);
      go <= 1'b0;
      axw(ADDR_CONTROL, ctl(0, MODE_CONFIG, 0, 0), r);
      chk("still_on", 1, on);
      n = 0;
      d = 32'h0;
      d[BUSY_BIT] = 1'b1;
      while (d[BUSY_BIT] !== 1'b0 && n < 40) begin
         axr(ADDR_CONTROL, d, r);
         if (n == 0) chk("busy", 1, d[BUSY_BIT]);
         n++;
      end
      chk("busy_clr", 0, d[BUSY_BIT]);
      chk("idle", 0, act);
      chk("off", 0, on);
      $display("t_power done");
   endtask
   task automatic t_stamp;
      logic [31:0] d, e;
      logic [1:0] r;
      logic s;
      axw(ADDR_CONTROL, ctl(0, MODE_CONFIG, 0, 1), r);
      axr(ADDR_TIMER, d, r);
      tick(5);
      axr(ADDR_TIMER, e, r);
      chk("halt", d, e);
      rx_pulse(s);
      chk("nostamp", 0, s);
      axw(ADDR_CONTROL, ctl(0, MODE_CONFIG, 1, 1), r);
      axr(ADDR_TIMER, d, r);
      tick(5);
      axr(ADDR_TIMER, e, r);
      chk("run", 1, d !== e);
      rx_pulse(s);
      chk("stamp", 1, s);
      axr(ADDR_TIMER, e, r);
      chk("stamp_val", 32'(e[15:0] - 16'h4), st);
      $display("t_stamp done");
   endtask
   task automatic t_map;
      logic [31:0] d;
      logic [1:0] r;
      axr(ADDR_STATUS, d, r);
      chk("rresp", RESP_SLVERR, r);
      chk("rdata", 0, d);
      axw(ADDR_STATUS, 32'hffff_ffff, r);
      chk("bresp", RESP_SLVERR, r);
      axr(ADDR_CONTROL, d, r);
      chk("ctl_kept", ctl(0, MODE_CONFIG, 1, 1), d & ctl(1, 3'h7, 1, 1));
      $display("t_map done");
   endtask
   // ****
   // run control
   // ****
   task automatic stop_test;
      $display("checks %0d errors %0d", checked, err_total);
      if (err_total == 0 && checked > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   // cycle ceiling
   always @(posedge clk_i) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         err_total++;
         stop_test();
      end
   end
   // main sequence
   initial begin
      repeat (4) @(posedge clk_i);
      rst_n_i <= 1'b1;
      tick(1);
      t_reset();
      t_modes();
      t_abort();
      t_power();
      t_stamp();
      t_map();
      stop_test();
   end
endmodule // tb
